/* File: pdt_top.sv */
`timescale 1ns/100ps

// How it works
// R1: The register set answers word reads and writes at base address fffec600 and nowhere else.
// R2: Software loads the start count before setting the enable bit.
// R3: The enable bit of the control register starts the count when 1 and halts it when 0.
// R4: While enabled the count value decrements until it reaches zero.
// R5: Reaching zero sets the expiry flag in the status register for software to poll.
// R6: Writing 1 to the expiry flag clears it and writing 0 leaves it alone.
// R7: With the interrupt-enable bit at 1 an expiry raises the interrupt request; the code also needs the expiry bit of the mask register at 1.
// R8: With auto-repeat at 0 the timer stops at zero and holds there.
// R9: With auto-repeat at 1 the load value is copied back and counting goes on without a pause.
// R10: A read of the counter register returns the present count.
// R11: The counting logic runs on the block clock, nominally 200 MHz.
// R12: The count drops once every prescaler plus one clock cycles.
// R13: A write to the load register also copies the value into the count at once.
module pdt_top #(
  parameter int unsigned CNT_W = 32                       // Counter width
) (
  input  wire logic                        sys_clk_i,     // Block clock
  input  wire logic                        rst_i,         // Async reset, active high
  input  wire logic [pdt_pkg::ADDR_W-1:0]  addr_i,        // Byte address
  input  wire logic [pdt_pkg::DATA_W-1:0]  wr_data_i,     // Write data
  input  wire logic                        wr_i,          // Write strobe
  input  wire logic                        rd_i,          // Read strobe
  output logic      [pdt_pkg::DATA_W-1:0]  rd_data_o,     // Read data, cycle after rd_i
  output logic                             irq_o          // Interrupt request, level
);

  // Address decode within the block's word window
  function automatic logic reg_hit(input logic [pdt_pkg::ADDR_W-1:0] a,
                                   input logic [7:0]                 off);
    reg_hit = (a[31:8] == pdt_pkg::BASE_UPPER) && (a[7:0] == off);
  endfunction : reg_hit

  // Strobe decodes
  logic wr_load;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic rd_evt;
  assign wr_load = wr_i && reg_hit(addr_i, pdt_pkg::OFF_LOAD);   // [R1]
  assign wr_ctrl = wr_i && reg_hit(addr_i, pdt_pkg::OFF_CTRL);   // [R1]
  assign wr_stat = wr_i && reg_hit(addr_i, pdt_pkg::OFF_STATUS); // [R1]
  assign wr_mask = wr_i && reg_hit(addr_i, pdt_pkg::OFF_MASK);   // [R1]
  assign rd_evt  = rd_i && reg_hit(addr_i, pdt_pkg::OFF_EVT);    // [R1]

  // Register state
  logic [CNT_W-1:0]                load_q, load_d;
  logic [CNT_W-1:0]                cnt_q, cnt_d;
  logic [pdt_pkg::PRE_W-1:0]       pre_q, pre_d;
  pdt_pkg::pdt_ctrl_s              ctrl_q, ctrl_d;
  logic                            exp_q, exp_d;
  logic [pdt_pkg::EVT_W-1:0]       evt_q, evt_d;
  logic [pdt_pkg::EVT_W-1:0]       mask_q, mask_d;
  logic [pdt_pkg::DATA_W-1:0]      rdat_q, rdat_d;
  logic                            irq_q, irq_d;

  logic tick;
  logic expire;

  // Prescaler: one tick every presc+1 enabled cycles
  // Compare is >= so a smaller limit written mid-phase ends the phase at once, no wrap
  always_comb begin
    tick  = 1'b0;
    pre_d = pre_q;
    if (wr_load || !ctrl_q.en) begin
      pre_d = '0;                                                  // Restart phase on new period
    end else if (pre_q >= ctrl_q.presc) begin
      tick  = 1'b1;                                                // [R12]
      pre_d = '0;
    end else begin
      pre_d = pre_q + 1'b1;                                        // [R12]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  // Count: decrement, stop or reload at zero
  always_comb begin
    load_d = load_q;
    cnt_d  = cnt_q;
    expire = 1'b0;
    if (wr_load) begin
      load_d = wr_data_i[CNT_W-1:0];
      cnt_d  = wr_data_i[CNT_W-1:0];                              // [R13]
    end else if (tick) begin                                      // [R3]
      if (cnt_q == CNT_W'(1)) begin
        cnt_d  = '0;                                              // [R4]
        expire = 1'b1;                                            // [R5]
      end else if (cnt_q != '0) begin
        cnt_d = cnt_q - 1'b1;                                     // [R4]
      end else if (ctrl_q.auto_rld) begin
        cnt_d = load_q;                                           // [R9]
      end else begin
        cnt_d = '0;                                               // [R8]
      end
    end
  end

  // Count registers run on the block clock; the counting rate in time scales with it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin  // [R11]
    if (rst_i) begin
      load_q <= pdt_pkg::LOAD_RST[CNT_W-1:0];
      cnt_q  <= pdt_pkg::LOAD_RST[CNT_W-1:0];
    end else begin
      load_q <= load_d;
      cnt_q  <= cnt_d;
    end
  end

  // Control register and flags; a set always beats a clear in the same cycle
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    exp_d  = exp_q;
    evt_d  = evt_q;
    if (wr_ctrl) begin
      ctrl_d.en       = wr_data_i[pdt_pkg::CTRL_EN_BIT];          // [R3]
      ctrl_d.auto_rld = wr_data_i[pdt_pkg::CTRL_AUTO_BIT];
      ctrl_d.irq_en   = wr_data_i[pdt_pkg::CTRL_IRQ_BIT];
      ctrl_d.presc    = wr_data_i[pdt_pkg::CTRL_PRE_LSB +: pdt_pkg::PRE_W];
    end
    if (wr_mask) begin
      mask_d = wr_data_i[pdt_pkg::EVT_W-1:0];
    end
    if (wr_stat && wr_data_i[pdt_pkg::STAT_EXP_BIT]) begin
      exp_d = 1'b0;                                               // [R6]
    end
    if (rd_evt) begin
      evt_d = '0;                                                 // Read clears
    end
    if (expire) begin
      exp_d    = 1'b1;                                            // [R5]
      evt_d[pdt_pkg::STAT_EXP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= pdt_pkg::CTRL_RST;
      mask_q <= pdt_pkg::MASK_RST;
      exp_q  <= 1'b0;
      evt_q  <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      exp_q  <= exp_d;
      evt_q  <= evt_d;
    end
  end

  // Read mux and interrupt; both registered so outputs come from flops
  always_comb begin
    rdat_d = '0;                                                  // Unmapped reads give zero
    if (rd_i) begin
      if (reg_hit(addr_i, pdt_pkg::OFF_LOAD)) begin
        rdat_d[CNT_W-1:0] = load_q;
      end else if (reg_hit(addr_i, pdt_pkg::OFF_COUNT)) begin
        rdat_d[CNT_W-1:0] = cnt_q;                                // [R10]
      end else if (reg_hit(addr_i, pdt_pkg::OFF_CTRL)) begin
        rdat_d[pdt_pkg::CTRL_EN_BIT]   = ctrl_q.en;
        rdat_d[pdt_pkg::CTRL_AUTO_BIT] = ctrl_q.auto_rld;
        rdat_d[pdt_pkg::CTRL_IRQ_BIT]  = ctrl_q.irq_en;
        rdat_d[pdt_pkg::CTRL_PRE_LSB +: pdt_pkg::PRE_W] = ctrl_q.presc;
      end else if (reg_hit(addr_i, pdt_pkg::OFF_STATUS)) begin
        rdat_d[pdt_pkg::STAT_EXP_BIT] = exp_q;
      end else if (reg_hit(addr_i, pdt_pkg::OFF_EVT)) begin
        rdat_d[pdt_pkg::EVT_W-1:0] = evt_q;
      end else if (reg_hit(addr_i, pdt_pkg::OFF_MASK)) begin
        rdat_d[pdt_pkg::EVT_W-1:0] = mask_q;
      end
    end
    // Gating on irq_en lets software poll without the line firing
    irq_d = ctrl_d.irq_en && |(evt_d & mask_d);                   // [R7]
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdat_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      rdat_q <= rdat_d;
      irq_q  <= irq_d;
    end
  end

  assign rd_data_o = rdat_q;
  assign irq_o     = irq_q;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_load_copies_count: assert property (            // [R13]
    wr_load |=> cnt_q == $past(wr_data_i[CNT_W-1:0]))
    else $error("Load write did not set the count");

  a_halt_when_off: assert property (                 // [R3]
    (!ctrl_q.en && !wr_load) |=> $stable(cnt_q))
    else $error("Count moved while disabled");

  a_presc_zero_rate: assert property (               // [R12]
    (ctrl_q.en && ctrl_q.presc == '0 && !wr_load && !wr_ctrl && pre_q == '0
     && cnt_q > CNT_W'(1)) |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("Prescaler zero did not decrement each cycle");

  a_presc_one_rate: assert property (                // [R12]
    (ctrl_q.en && ctrl_q.presc == 8'h01 && pre_q == '0 && cnt_q > CNT_W'(2)
     && !wr_load && !wr_ctrl) ##1 (!wr_load && !wr_ctrl)
     |=> cnt_q == $past(cnt_q, 2) - 1'b1)
    else $error("Prescaler one did not halve the rate");

  a_zero_sets_flag: assert property (                // [R5]
    (cnt_q == CNT_W'(1) && tick && !wr_load) |=> (exp_q && cnt_q == '0))
    else $error("Expiry flag not set at zero");

  a_w1c_clears: assert property (                    // [R6]
    (wr_stat && wr_data_i[pdt_pkg::STAT_EXP_BIT] && !expire) |=> !exp_q)
    else $error("Write one did not clear expiry flag");

  a_w0_keeps: assert property (                      // [R6]
    (exp_q && !(wr_stat && wr_data_i[pdt_pkg::STAT_EXP_BIT])) |=> exp_q)
    else $error("Expiry flag dropped without a write one");

  a_one_shot_hold: assert property (                 // [R8]
    (cnt_q == '0 && !ctrl_q.auto_rld && !wr_load && !wr_ctrl)
    |=> cnt_q == '0)
    else $error("One-shot timer left zero");

  a_auto_reload: assert property (                   // [R9]
    (cnt_q == '0 && ctrl_q.auto_rld && tick && !wr_load)
    |=> cnt_q == $past(load_q))
    else $error("Auto-repeat did not reload");

  a_count_readback: assert property (                // [R10]
    (rd_i && reg_hit(addr_i, pdt_pkg::OFF_COUNT))
    |=> rd_data_o[CNT_W-1:0] == $past(cnt_q))
    else $error("Counter read returned wrong value");

  a_irq_on_expire: assert property (                 // [R7]
    (expire && ctrl_q.irq_en && mask_q[pdt_pkg::STAT_EXP_BIT] && !wr_ctrl && !wr_mask)
    |=> irq_o ##1 (irq_o || $past(rd_evt) || $past(wr_ctrl) || $past(wr_mask)))
    else $error("Expiry with interrupts on did not raise irq");

  // The interrupt line is a registered copy of enable, event and mask, nothing else
  a_irq_level: assert property (                     // [R7]
    irq_o == (ctrl_q.irq_en && |(evt_q & mask_q)))
    else $error("Interrupt line disagrees with its sources");

  // Reading the event word clears it unless a new expiry lands in the same cycle
  a_evt_read_clears: assert property (               // [R7]
    (rd_evt && !expire) |=> evt_q == '0)
    else $error("Event read did not clear the event word");

  a_evt_sticky: assert property (                    // [R7]
    (evt_q[pdt_pkg::STAT_EXP_BIT] && !rd_evt) |=> evt_q[pdt_pkg::STAT_EXP_BIT])
    else $error("Event bit dropped without a read");

  // The count may move only on a tick or a load write
  a_count_moves_on_tick: assert property (           // [R4]
    (!tick && !wr_load) |=> $stable(cnt_q))
    else $error("Count moved without a tick");

  a_decrement_step: assert property (                // [R4]
    (tick && !wr_load && cnt_q > CNT_W'(1)) |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("Tick did not take exactly one off the count");

  // A phase left above a newly written smaller prescaler must restart, not wrap round
  a_pre_bounded: assert property (                   // [R12]
    (pre_q > ctrl_q.presc) |=> pre_q == '0)
    else $error("Prescaler ran past its limit");

  // Longest legal gap between ticks, set by the widest prescaler value
  localparam int TICK_GAP_MAX = (1 << pdt_pkg::PRE_W) - 1;

  a_tick_arrives: assert property (                  // [R12]
    (ctrl_q.en && pre_q == '0 && !wr_load && !wr_ctrl)
    |-> ##[0:TICK_GAP_MAX] (tick || wr_load || wr_ctrl))
    else $error("Enabled prescaler gave no tick in time");

  // Read data stand for one cycle only, so a stale word never lingers on the bus
  a_read_idle_zero: assert property (                // [R1]
    !rd_i |=> rd_data_o == '0)
    else $error("Read data not zero outside a read");

  a_foreign_read_zero: assert property (             // [R1]
    (rd_i && addr_i[31:8] != pdt_pkg::BASE_UPPER) |=> rd_data_o == '0)
    else $error("Read outside the block returned data");

  a_load_readback: assert property (                 // [R1]
    (rd_i && reg_hit(addr_i, pdt_pkg::OFF_LOAD))
    |=> rd_data_o[CNT_W-1:0] == $past(load_q))
    else $error("Load read returned wrong value");

  a_flag_readback: assert property (                 // [R5]
    (rd_i && reg_hit(addr_i, pdt_pkg::OFF_STATUS))
    |=> rd_data_o[pdt_pkg::STAT_EXP_BIT] == $past(exp_q))
    else $error("Status read returned wrong flag");

  // Check helper: ticks since the last expiry. Any load or control write spoils the
  // measurement, so only periods that ran undisturbed from expiry to expiry are judged.
  logic [CNT_W:0] per_ticks_q, per_ticks_d;
  logic           per_clean_q, per_clean_d;

  // Helper next state
  always_comb begin
    per_ticks_d = per_ticks_q;
    per_clean_d = per_clean_q;
    if (wr_load || wr_ctrl) begin
      per_clean_d = 1'b0;
    end
    if (tick) begin
      per_ticks_d = per_ticks_q + 1'b1;
    end
    if (expire) begin
      per_ticks_d = '0;
      per_clean_d = !(wr_load || wr_ctrl);
    end
  end

  // Helper registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_ticks_q <= '0;
      per_clean_q <= 1'b0;
    end else begin
      per_ticks_q <= per_ticks_d;
      per_clean_q <= per_clean_d;
    end
  end

  // An undisturbed auto-repeat period is load+1 ticks: the reload, then load down to zero
  a_auto_period: assert property (                   // [R9]
    (expire && per_clean_q && ctrl_q.auto_rld)
    |-> per_ticks_q == {1'b0, load_q})
    else $error("Auto-repeat period has the wrong length");

  // Main scenarios
  c_one_shot:  cover property (ctrl_q.en && !ctrl_q.auto_rld && expire);
  c_auto_loop: cover property (expire ##[1:300] (cnt_q == '0 && tick && ctrl_q.auto_rld));
  c_irq_clear: cover property (irq_o ##1 rd_evt ##1 !irq_o);
  c_set_race:  cover property (expire && wr_stat && wr_data_i[pdt_pkg::STAT_EXP_BIT]);
  c_slow_tick: cover property (tick && ctrl_q.presc != '0);

endmodule : pdt_top

/* File: pdt_pkg.sv */
package pdt_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // Register block location and word offsets
  localparam logic [31:0] BASE_ADDR   = 32'hfffec600;
  localparam logic [7:0]  OFF_LOAD    = 8'h00;
  localparam logic [7:0]  OFF_COUNT   = 8'h04;
  localparam logic [7:0]  OFF_CTRL    = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0c;
  localparam logic [7:0]  OFF_EVT     = 8'h10;
  localparam logic [7:0]  OFF_MASK    = 8'h14;
  localparam logic [23:0] BASE_UPPER  = BASE_ADDR[31:8];

  // Control field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_AUTO_BIT  = 1;
  localparam int unsigned CTRL_IRQ_BIT   = 2;
  localparam int unsigned CTRL_PRE_LSB   = 8;
  localparam int unsigned PRE_W          = 8;

  // Status and event bit positions
  localparam int unsigned STAT_EXP_BIT = 0;
  localparam int unsigned EVT_W        = 1;

  // Reset values
  localparam logic [31:0]      LOAD_RST = 32'h00000000;
  localparam logic [EVT_W-1:0] MASK_RST = 1'h1;

  // Counting clock rate of the original part
  localparam int unsigned COUNT_CLK_MHZ = 200;

  // Control register contents
  typedef struct packed {
    logic [PRE_W-1:0] presc;
    logic             irq_en;
    logic             auto_rld;
    logic             en;
  } pdt_ctrl_s;

  localparam pdt_ctrl_s CTRL_RST = '{presc: 8'h00, irq_en: 1'b0, auto_rld: 1'b0, en: 1'b0};

endpackage : pdt_pkg

/* File: tb_private_down_timer.sv */
`timescale 1ns/100ps

module tb_private_down_timer;
  logic        sys_clk_i;
  logic        rst_i;
  logic [31:0] addr_i;
  logic [31:0] wr_data_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rd_data_o;
  logic        irq_o;
  int          err_total;
  int          comparisons;
  logic [31:0] va;
  logic [31:0] vb;

  pdt_top pdt_top_i (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .addr_i    (addr_i),
    .wr_data_i (wr_data_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rd_data_o (rd_data_o),
    .irq_o     (irq_o)
  );

  // 10 MHz block clock
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One-cycle write strobe; offset selects the word inside the block
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i      <= 1'b1;
    addr_i    <= {pdt_pkg::BASE_UPPER, off};
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr_i      <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rda(input logic [31:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1 v = rd_data_o;
  endtask : rda

  task automatic rd(input logic [7:0] off, output logic [31:0] v);
    rda({pdt_pkg::BASE_UPPER, off}, v);
  endtask : rd

  task automatic rchk(input string n, input logic [7:0] off, input logic [31:0] e);
    logic [31:0] v;
    rd(off, v);
    chk(n, e, v);
  endtask : rchk

  task automatic t_reset;
    rchk("load", pdt_pkg::OFF_LOAD, 32'h00000000);
    rchk("count", pdt_pkg::OFF_COUNT, 32'h00000000);
    rchk("ctrl", pdt_pkg::OFF_CTRL, 32'h00000000);
    rchk("status", pdt_pkg::OFF_STATUS, 32'h00000000);
    rchk("mask", pdt_pkg::OFF_MASK, 32'h00000001);
    rchk("unmapped", 8'h18, 32'h00000000);
    // Same offset under another base must not reach the load word
    @(posedge sys_clk_i);
    wr_i      <= 1'b1;
    addr_i    <= 32'hfffec700;
    wr_data_i <= 32'h00000055;
    @(posedge sys_clk_i);
    wr_i      <= 1'b0;
    rchk("load_alias", pdt_pkg::OFF_LOAD, 32'h00000000);
  endtask : t_reset

  task automatic t_oneshot;
    wr(pdt_pkg::OFF_LOAD, 32'h00000003);
    rchk("count_load", pdt_pkg::OFF_COUNT, 32'h00000003);
    wr(pdt_pkg::OFF_CTRL, 32'h00000005);
    repeat (12) @(posedge sys_clk_i);
    rchk("count_hold", pdt_pkg::OFF_COUNT, 32'h00000000);
    rchk("flag_set", pdt_pkg::OFF_STATUS, 32'h00000001);
    chk("irq_hi", 32'h1, {31'h0, irq_o});
    wr(pdt_pkg::OFF_STATUS, 32'h00000000);
    rchk("flag_w0", pdt_pkg::OFF_STATUS, 32'h00000001);
    wr(pdt_pkg::OFF_STATUS, 32'h00000001);
    rchk("flag_w1", pdt_pkg::OFF_STATUS, 32'h00000000);
    rchk("event", pdt_pkg::OFF_EVT, 32'h00000001);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("irq_clr", 32'h0, {31'h0, irq_o});
    wr(pdt_pkg::OFF_CTRL, 32'h00000000);
  endtask : t_oneshot

  // Eight cycles span exactly two ticks at prescaler 3, four at 1, eight at 0
  task automatic t_rate;
    wr(pdt_pkg::OFF_LOAD, 32'h00000100);
    wr(pdt_pkg::OFF_CTRL, 32'h00000301);
    rd(pdt_pkg::OFF_COUNT, va);
    repeat (6) @(posedge sys_clk_i);
    rd(pdt_pkg::OFF_COUNT, vb);
    chk("rate_p3", 32'h00000002, va - vb);
    wr(pdt_pkg::OFF_CTRL, 32'h00000000);
    rd(pdt_pkg::OFF_COUNT, va);
    repeat (6) @(posedge sys_clk_i);
    rd(pdt_pkg::OFF_COUNT, vb);
    chk("frozen", va, vb);
    rda(32'hfffed604, vb);
    chk("foreign_rd", 32'h00000000, vb);
    wr(pdt_pkg::OFF_CTRL, 32'h00000001);
    rd(pdt_pkg::OFF_COUNT, va);
    repeat (6) @(posedge sys_clk_i);
    rd(pdt_pkg::OFF_COUNT, vb);
    chk("rate_p0", 32'h00000008, va - vb);
    wr(pdt_pkg::OFF_CTRL, 32'h00000101);
    rd(pdt_pkg::OFF_COUNT, va);
    repeat (6) @(posedge sys_clk_i);
    rd(pdt_pkg::OFF_COUNT, vb);
    chk("rate_p1", 32'h00000004, va - vb);
    wr(pdt_pkg::OFF_CTRL, 32'h00000000);
  endtask : t_rate

  // Reload cycle runs 3,2,1,0 so two reads two cycles apart differ by two modulo four
  task automatic t_auto;
    wr(pdt_pkg::OFF_LOAD, 32'h00000003);
    wr(pdt_pkg::OFF_STATUS, 32'h00000001);
    wr(pdt_pkg::OFF_MASK, 32'h00000000);
    wr(pdt_pkg::OFF_CTRL, 32'h00000007);
    repeat (20) @(posedge sys_clk_i);
    rd(pdt_pkg::OFF_COUNT, va);
    rd(pdt_pkg::OFF_COUNT, vb);
    chk("auto_range", 32'h00000000, va & 32'hfffffffc);
    chk("auto_step", (va + 32'h2) & 32'h3, vb);
    rchk("auto_flag", pdt_pkg::OFF_STATUS, 32'h00000001);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    wr(pdt_pkg::OFF_MASK, 32'h00000001);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("irq_unmask", 32'h1, {31'h0, irq_o});
    wr(pdt_pkg::OFF_CTRL, 32'h00000000);
    rd(pdt_pkg::OFF_EVT, va);
  endtask : t_auto

  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Whole run needs about 150 cycles; the 5000-cycle limit allows ample margin
  initial begin
    #500000;
    err_total++;
    final_report();
  end

  initial begin
    err_total   = 0;
    comparisons = 0;
    rst_i       = 1'b1;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    addr_i      = 32'h00000000;
    wr_data_i   = 32'h00000000;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk("irq_rst", 32'h0, {31'h0, irq_o});
    t_reset();
    t_oneshot();
    t_rate();
    t_auto();
    final_report();
  end
endmodule : tb_private_down_timer
